// ===== rtl/ppds_port_ctrl.sv
// One copper port; controls are plain ports, timers sized for 250 MHz.
// Assumes link, energy and loop-back inputs are synchronous to clk.
`timescale 1ns/100ps
module ppds_port_ctrl #(
  parameter int DET_LIMIT_CYC = ppds_pkg::DET_LIMIT_MS * ppds_pkg::CYC_PER_MS,
  parameter int MS_CYC = ppds_pkg::CYC_PER_MS,
  parameter logic [15:0] LFSR_SEED = ppds_pkg::LFSR_SEED
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic det_enable,
  input wire logic autoneg_enable,
  input wire logic pm_enable,
  input wire logic [1:0] sleep_sel,
  input wire logic [1:0] wake_sel,
  input wire logic [1:0] link_to_sel,
  input wire logic loopback_seen,
  input wire logic energy_detect,
  input wire logic link_up_in,
  input wire logic burst_done,
  input wire logic irq_flag_read,
  output logic [1:0] det_status,
  output logic det_irq_flag,
  output logic management_interrupt_out,
  output logic special_flp_tx,
  output logic autoneg_run,
  output logic link_status,
  output logic wake_burst_tx,
  output logic wake_pair_b,
  output logic digital_power_down,
  output logic [1:0] pm_state
);

  // Milliseconds to cycles, never below one
  function automatic logic [31:0] ms_to_cyc(input int ms);
    int c;
    c = ms * MS_CYC;
    if (c < 1) begin
      c = 1;
    end
    return c[31:0];
  endfunction : ms_to_cyc

  function automatic logic [31:0] pick4(input logic [1:0] s, input int a, input int b,
                                        input int c, input int d);
    int v;
    case (s)
      2'h0: v = a;
      2'h1: v = b;
      2'h2: v = c;
      default: v = d;
    endcase
    return ms_to_cyc(v);
  endfunction : pick4

  logic [1:0] det_status_r;
  logic [31:0] det_cnt_r;
  logic det_irq_r;
  logic mint_r;
  logic flp_r;
  logic an_run_r;
  logic link_r;
  logic link_seen_r;
  logic [31:0] pm_cnt_r;
  logic [31:0] pm_limit_r;
  logic [1:0] burst_cnt_r;
  logic pair_b_r;
  logic wake_tx_r;
  logic forced_stay_r;
  logic pd_r;
  ppds_pkg::ppds_pm_state_t pm_r;
  ppds_pkg::ppds_pm_state_t pm_nxt;
  logic [15:0] rnd;
  logic det_active;
  logic loop_evt;
  logic det_expire;
  logic pm_load_r;
  logic pm_expired;
  logic wake_entry;
  logic [31:0] sleep_base;
  logic [31:0] sleep_off;
  logic [31:0] sleep_dwell;

  ppds_lfsr #(
    .SEED(LFSR_SEED)
  ) u_lfsr (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .value(rnd)
  );

  assign det_active = det_enable && autoneg_enable && (det_status_r == ppds_pkg::DET_SEARCH);
  assign loop_evt = det_active && loopback_seen;
  assign det_expire = det_cnt_r >= 32'(DET_LIMIT_CYC - 1);
  assign pm_expired = pm_cnt_r >= pm_limit_r;
  assign wake_entry = pm_nxt == ppds_pkg::PPDS_WAKE && pm_r != ppds_pkg::PPDS_WAKE;

  // Detection status machine
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      det_status_r <= ppds_pkg::DET_SEARCH;
      det_cnt_r <= 32'h0000_0000;
    end else if (ce) begin
      if (!det_enable) begin
        det_status_r <= ppds_pkg::DET_SEARCH;
        det_cnt_r <= 32'h0000_0000;
      end else if (det_active) begin
        if (loopback_seen) begin
          det_status_r <= ppds_pkg::DET_NEED_PWR;
        end else if (det_expire) begin
          det_status_r <= ppds_pkg::DET_TIMEOUT;
        end else begin
          det_cnt_r <= det_cnt_r + 32'h0000_0001;
        end
      end else if (det_status_r == ppds_pkg::DET_TIMEOUT && link_seen_r && !link_up_in) begin
        det_status_r <= ppds_pkg::DET_SEARCH;
        det_cnt_r <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flp_r <= 1'b0;
    end else if (ce) begin
      // Stop with the expiring edge so pulses never outlive the search
      flp_r <= det_active && !loopback_seen && !det_expire;
    end
  end

  // sticky flag, set beats read clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      det_irq_r <= 1'b0;
    end else if (ce) begin
      if (loop_evt) begin
        det_irq_r <= 1'b1;
      end else if (irq_flag_read) begin
        det_irq_r <= 1'b0;
      end
    end
  end

  // interrupt raised and dropped with flag
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mint_r <= 1'b0;
    end else if (ce) begin
      if (loop_evt) begin
        mint_r <= 1'b1;
      end else if (irq_flag_read) begin
        mint_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      an_run_r <= 1'b0;
      link_r <= 1'b0;
    end else if (ce) begin
      an_run_r <= autoneg_enable && (!det_enable || det_status_r == ppds_pkg::DET_TIMEOUT)
                  && pm_r == ppds_pkg::PPDS_NORMAL;
      link_r <= link_up_in && pm_r == ppds_pkg::PPDS_NORMAL;
    end
  end

  // remember link to spot its failure
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      link_seen_r <= 1'b0;
    end else if (ce) begin
      if (det_status_r != ppds_pkg::DET_TIMEOUT || !link_up_in) begin
        link_seen_r <= 1'b0;
      end else begin
        link_seen_r <= 1'b1;
      end
    end
  end

  always_comb begin
    sleep_base = pick4(sleep_sel, ppds_pkg::SLEEP_MS_0, ppds_pkg::SLEEP_MS_1,
                       ppds_pkg::SLEEP_MS_2, ppds_pkg::SLEEP_MS_3);
    sleep_off = ms_to_cyc(32'(rnd) % ppds_pkg::RAND_SPAN_MS);
    sleep_dwell = sleep_base + sleep_off - ms_to_cyc(ppds_pkg::RAND_LO_MS);
  end

  always_comb begin
    pm_nxt = pm_r;
    case (pm_r)
      ppds_pkg::PPDS_LOW_POWER: begin
        if (energy_detect) begin
          pm_nxt = ppds_pkg::PPDS_NORMAL;
        end else if (pm_expired) begin
          pm_nxt = ppds_pkg::PPDS_WAKE;
        end
      end
      ppds_pkg::PPDS_WAKE: begin
        if (energy_detect) begin
          pm_nxt = ppds_pkg::PPDS_NORMAL;
        // back to sleep after wake window
        end else if (pm_expired) begin
          pm_nxt = ppds_pkg::PPDS_LOW_POWER;
        end
      end
      ppds_pkg::PPDS_NORMAL: begin
        if (!forced_stay_r && !link_up_in && pm_expired) begin
          pm_nxt = ppds_pkg::PPDS_LOW_POWER;
        end
      end
      default: pm_nxt = ppds_pkg::PPDS_LOW_POWER;
    endcase
    if (!pm_enable) begin
      pm_nxt = ppds_pkg::PPDS_NORMAL;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pm_r <= ppds_pkg::PPDS_LOW_POWER;
    end else if (ce) begin
      pm_r <= pm_nxt;
    end
  end

  // Reset leaves no real dwell; force a load on the first enabled cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pm_load_r <= 1'b1;
    end else if (ce) begin
      pm_load_r <= 1'b0;
    end
  end

  // Dwell counter, reloaded on every state change
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pm_cnt_r <= 32'h0000_0000;
      pm_limit_r <= 32'h0000_0001;
    end else if (ce) begin
      if (pm_load_r || pm_nxt != pm_r || (pm_r == ppds_pkg::PPDS_NORMAL && link_up_in)) begin
        pm_cnt_r <= 32'h0000_0000;
        case (pm_nxt)
          ppds_pkg::PPDS_LOW_POWER: pm_limit_r <= sleep_dwell;
          ppds_pkg::PPDS_WAKE: pm_limit_r <= pick4(wake_sel, ppds_pkg::WAKE_MS_0,
            ppds_pkg::WAKE_MS_1, ppds_pkg::WAKE_MS_2, ppds_pkg::WAKE_MS_3);
          default: pm_limit_r <= pick4(link_to_sel, ppds_pkg::LINK_TO_MS_0,
            ppds_pkg::LINK_TO_MS_1, ppds_pkg::LINK_TO_MS_2, ppds_pkg::LINK_TO_MS_3);
        endcase
      end else if (pm_cnt_r < pm_limit_r) begin
        pm_cnt_r <= pm_cnt_r + 32'h0000_0001;
      end
    end
  end

  // forced mode holds normal after arrival
  // autoneg off in normal pins the state
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      forced_stay_r <= 1'b0;
    end else if (ce) begin
      if (autoneg_enable) begin
        forced_stay_r <= 1'b0;
      end else if (pm_nxt == ppds_pkg::PPDS_NORMAL) begin
        forced_stay_r <= 1'b1;
      end
    end
  end

  // up to three bursts, alternating pairs
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      burst_cnt_r <= 2'h0;
      pair_b_r <= 1'b0;
      wake_tx_r <= 1'b0;
    end else if (ce) begin
      if (pm_nxt != ppds_pkg::PPDS_WAKE) begin
        burst_cnt_r <= 2'h0;
        pair_b_r <= 1'b0;
        wake_tx_r <= 1'b0;
      end else if (wake_entry) begin
        wake_tx_r <= 1'b1;
      end else if (burst_done && wake_tx_r) begin
        burst_cnt_r <= burst_cnt_r + 2'h1;
        pair_b_r <= !pair_b_r;
        wake_tx_r <= (burst_cnt_r != 2'h2);
      end
    end
  end

  // only datapath gated; interrupt logic stays clocked
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pd_r <= 1'b1;
    end else if (ce) begin
      pd_r <= pm_nxt != ppds_pkg::PPDS_NORMAL;
    end
  end

  assign det_status = det_status_r;
  assign det_irq_flag = det_irq_r;
  assign management_interrupt_out = mint_r;
  assign special_flp_tx = flp_r;
  assign autoneg_run = an_run_r;
  assign link_status = link_r;
  assign wake_burst_tx = wake_tx_r;
  assign wake_pair_b = pair_b_r;
  assign digital_power_down = pd_r;
  assign pm_state = pm_r;

endmodule : ppds_port_ctrl

// ===== rtl/ppds_pkg.sv
// Package for the per-port power detect and sleep control block.
// Assumes a 250 MHz clock; timer codes are decoded inside the main module.
package ppds_pkg;

  localparam int CLK_MHZ = 250;
  localparam int CYC_PER_MS = CLK_MHZ * 1000;

  // Detection status codes
  localparam logic [1:0] DET_SEARCH = 2'h0;
  localparam logic [1:0] DET_NEED_PWR = 2'h1;
  localparam logic [1:0] DET_TIMEOUT = 2'h2;

  // Times in milliseconds
  localparam int DET_LIMIT_MS = 1000;
  localparam int SLEEP_MS_0 = 1000;
  localparam int SLEEP_MS_1 = 2000;
  localparam int SLEEP_MS_2 = 3000;
  localparam int SLEEP_MS_3 = 4000;
  localparam int WAKE_MS_0 = 160;
  localparam int WAKE_MS_1 = 400;
  localparam int WAKE_MS_2 = 800;
  localparam int WAKE_MS_3 = 2000;
  localparam int LINK_TO_MS_0 = 1000;
  localparam int LINK_TO_MS_1 = 2000;
  localparam int LINK_TO_MS_2 = 3000;
  localparam int LINK_TO_MS_3 = 4000;
  localparam int RAND_LO_MS = 80;
  localparam int RAND_HI_MS = 60;
  localparam int RAND_SPAN_MS = RAND_LO_MS + RAND_HI_MS;

  // Reset values
  localparam logic [1:0] SLEEP_SEL_RST = 2'h1;
  localparam logic [15:0] LFSR_SEED = 16'hACE1;

  typedef enum logic [1:0] {
    PPDS_LOW_POWER = 2'b00,
    PPDS_WAKE = 2'b01,
    PPDS_NORMAL = 2'b10
  } ppds_pm_state_t;

endpackage : ppds_pkg

// ===== rtl/ppds_lfsr.sv
// Free-running 16-bit pseudo-random source for sleep offsets.
// Assumes one clock, asynchronous active-low reset and a clock enable.
`timescale 1ns/100ps
module ppds_lfsr #(
  parameter logic [15:0] SEED = ppds_pkg::LFSR_SEED
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  output logic [15:0] value
);

  logic [15:0] lfsr_r;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lfsr_r <= ppds_pkg::LFSR_SEED;
    end else if (ce) begin
      lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
    end
  end

  assign value = lfsr_r ^ SEED ^ ppds_pkg::LFSR_SEED;

endmodule : ppds_lfsr

// ===== tb/ppds_port_ctrl_monitor.sv
// Checker of ppds_port_ctrl port behaviour.
// Bound to every ppds_port_ctrl; sees its ports only.
`timescale 1ns/100ps
module ppds_port_ctrl_monitor (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic det_enable,
  input wire logic autoneg_enable,
  input wire logic pm_enable,
  input wire logic loopback_seen,
  input wire logic energy_detect,
  input wire logic link_up_in,
  input wire logic [1:0] det_status,
  input wire logic det_irq_flag,
  input wire logic management_interrupt_out,
  input wire logic special_flp_tx,
  input wire logic link_status,
  input wire logic wake_burst_tx,
  input wire logic digital_power_down,
  input wire logic [1:0] pm_state
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_flp; special_flp_tx |-> det_status == 2'h0; endproperty
  a_flp: assert property (p_flp) else $error("pulses outside search");
  property p_loop;
    ce && det_enable && autoneg_enable && !pm_enable && loopback_seen && det_status == 2'h0
      |=> det_status == 2'h1;
  endproperty
  a_loop: assert property (p_loop) else $error("loop-back missed");
  property p_irq; management_interrupt_out == det_irq_flag; endproperty
  a_irq: assert property (p_irq) else $error("interrupt differs from flag");
  property p_flag; $rose(det_irq_flag) |-> det_status == 2'h1; endproperty
  a_flag: assert property (p_flag) else $error("flag without detection");
  property p_relink;
    ce && det_enable && det_status == 2'h2 && link_status && !link_up_in
      |-> ##[1:3] det_status == 2'h0;
  endproperty
  a_relink: assert property (p_relink) else $error("search not resumed");
  property p_state; pm_state != 2'b11; endproperty
  a_state: assert property (p_state) else $error("illegal state");
  property p_energy;
    ce && pm_enable && energy_detect && pm_state != ppds_pkg::PPDS_NORMAL
      |=> pm_state == ppds_pkg::PPDS_NORMAL;
  endproperty
  a_energy: assert property (p_energy) else $error("energy ignored");
  property p_pdn; digital_power_down == (pm_state != ppds_pkg::PPDS_NORMAL); endproperty
  a_pdn: assert property (p_pdn) else $error("power down wrong");
  property p_burst; $rose(wake_burst_tx) |-> pm_state == ppds_pkg::PPDS_WAKE; endproperty
  a_burst: assert property (p_burst) else $error("burst outside wake");
  c_need: cover property (det_status == 2'h1);
  c_wake: cover property (pm_state == ppds_pkg::PPDS_WAKE);
  c_link: cover property (det_status == 2'h2 && link_status);
endmodule : ppds_port_ctrl_monitor

bind ppds_port_ctrl ppds_port_ctrl_monitor u_mon (.clk, .rstn, .ce, .det_enable,
  .autoneg_enable, .pm_enable, .loopback_seen, .energy_detect, .link_up_in, .det_status,
  .det_irq_flag, .management_interrupt_out, .special_flp_tx, .link_status, .wake_burst_tx,
  .digital_power_down, .pm_state);

// ===== tb/ppds_link_partner.sv
// Link partner model on the copper side of one port.
// Assumes the bench drives unpowered and energy_on at clock edges.
`timescale 1ns/100ps
module ppds_link_partner (
  input wire logic clk,
  input wire logic unpowered,
  input wire logic energy_on,
  input wire logic special_flp_tx,
  input wire logic wake_burst_tx,
  output logic loopback_seen,
  output logic energy_detect,
  output logic burst_done
);
  logic [1:0] gap_r = 2'h0;
  initial begin
    loopback_seen = 1'b0;
    energy_detect = 1'b0;
    burst_done = 1'b0;
  end
  always @(posedge clk) begin
    loopback_seen <= unpowered && special_flp_tx;
    energy_detect <= energy_on;
    gap_r <= wake_burst_tx ? gap_r + 2'h1 : 2'h0;
    burst_done <= wake_burst_tx && gap_r == 2'h3;
  end
endmodule : ppds_link_partner

// ===== tb/tb_top.sv
// Bench for the port power detect and sleep controller.
// Short timers: one millisecond is MS clock cycles.
`timescale 1ns/100ps
module tb_top;
  localparam int MS = 10;
  localparam int DLIM = 50;
  logic clk = 0, rstn = 0, ce = 1, det_enable = 0, autoneg_enable = 1, pm_enable = 0;
  logic [1:0] sleep_sel = 2'h0, wake_sel = 2'h0, link_to_sel = 2'h0, det_status, pm_state;
  logic link_up_in = 0, irq_flag_read = 0, unpowered = 0, energy_on = 0;
  logic loopback_seen, energy_detect, burst_done, det_irq_flag, management_interrupt_out;
  logic special_flp_tx, autoneg_run, link_status, wake_burst_tx, wake_pair_b;
  logic digital_power_down;
  int mismatches = 0, comparisons = 0, n;
  always #2 clk = ~clk;
  ppds_port_ctrl #(.DET_LIMIT_CYC(DLIM), .MS_CYC(MS)) uut (.clk, .rstn, .ce, .det_enable,
    .autoneg_enable, .pm_enable, .sleep_sel, .wake_sel, .link_to_sel, .loopback_seen,
    .energy_detect, .link_up_in, .burst_done, .irq_flag_read, .det_status, .det_irq_flag,
    .management_interrupt_out, .special_flp_tx, .autoneg_run, .link_status,
    .wake_burst_tx, .wake_pair_b, .digital_power_down, .pm_state);
  ppds_link_partner lp (.clk, .unpowered, .energy_on, .special_flp_tx, .wake_burst_tx,
    .loopback_seen, .energy_detect, .burst_done);
  task automatic chk(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask : chk
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick
  task automatic test_done;
    if (mismatches == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  task automatic t_detect;
    @(posedge clk) det_enable <= 1;
    unpowered <= 1;
    for (n = 0; n < 5 && special_flp_tx !== 1'b1; n++) tick(1);
    chk(special_flp_tx === 1'b1 && det_status === 2'h0, "no search");
    for (n = 0; n < 20 && det_status !== 2'h1; n++) tick(1);
    chk(det_status === 2'h1 && special_flp_tx === 1'b0, "no need-power");
    chk(det_irq_flag === 1'b1 && management_interrupt_out === 1'b1, "no irq");
    @(posedge clk) irq_flag_read <= 1;
    unpowered <= 0;
    @(posedge clk) irq_flag_read <= 0;
    tick(1);
    chk(det_irq_flag === 1'b0 && management_interrupt_out === 1'b0, "irq stuck");
    @(posedge clk) ce <= 0;
    det_enable <= 0;
    tick(3);
    chk(det_status === 2'h1, "state moved with ce low");
    @(posedge clk) ce <= 1;
  endtask : t_detect
  task automatic t_timeout;
    @(posedge clk) det_enable <= 0;
    tick(3);
    @(posedge clk) det_enable <= 1;
    for (n = 0; n < DLIM + 20 && det_status !== 2'h2; n++) tick(1);
    chk(n >= DLIM - 3 && n <= DLIM + 3, "limit time");
    chk(special_flp_tx === 1'b0, "pulses after limit");
    tick(1);
    chk(autoneg_run === 1'b1, "no autoneg");
    @(posedge clk) link_up_in <= 1;
    tick(3);
    chk(link_status === 1'b1, "no link");
    @(posedge clk) link_up_in <= 0;
    tick(4);
    chk(det_status === 2'h0 && autoneg_run === 1'b0, "no re-detect");
    @(posedge clk) det_enable <= 0;
  endtask : t_timeout
  task automatic t_sleep;
    @(posedge clk) pm_enable <= 1;
    link_up_in <= 1;
    link_to_sel <= 2'h1;
    wake_sel <= 2'h1;
    tick(3);
    @(posedge clk) link_up_in <= 0;
    for (n = 0; n < 2100 * MS && pm_state !== ppds_pkg::PPDS_LOW_POWER; n++) tick(1);
    chk(n >= 2000 * MS - 3 && n <= 2000 * MS + 3, "link time-out");
    chk(digital_power_down === 1'b1, "awake in low power");
    for (n = 0; n < 1100 * MS && pm_state !== ppds_pkg::PPDS_WAKE; n++) tick(1);
    chk(n >= 920 * MS - 3 && n <= 1060 * MS + 3, "sleep dwell");
    for (n = 0; n < 5 && wake_burst_tx !== 1'b1; n++) tick(1);
    chk(wake_burst_tx === 1'b1 && wake_pair_b === 1'b0, "no burst on A");
    tick(6);
    chk(wake_pair_b === 1'b1, "pair not B");
    tick(8);
    chk(wake_burst_tx === 1'b0, "burst count");
    for (n = 0; n < 410 * MS && pm_state !== ppds_pkg::PPDS_LOW_POWER; n++) tick(1);
    chk(n >= 400 * MS - 20 && n <= 400 * MS + 3, "wake time");
    @(posedge clk) energy_on <= 1;
    tick(3);
    chk(pm_state === ppds_pkg::PPDS_NORMAL && digital_power_down === 1'b0, "no wake");
  endtask : t_sleep
  task automatic t_forced;
    @(posedge clk) autoneg_enable <= 0;
    link_to_sel <= 2'h0;
    link_up_in <= 1;
    tick(3);
    @(posedge clk) link_up_in <= 0;
    energy_on <= 0;
    tick(1100 * MS);
    chk(pm_state === ppds_pkg::PPDS_NORMAL, "left normal");
  endtask : t_forced
  initial begin
    tick(2);
    chk(pm_state === 2'h0 && digital_power_down === 1'b1 && det_status === 2'h0, "rst");
    @(posedge clk) rstn <= 1;
    t_detect();
    t_timeout();
    t_sleep();
    t_forced();
    test_done();
  end
  initial begin
    #(4 * 70000);
    mismatches++;
    test_done();
  end
endmodule : tb_top
